// *** uart_receiver_path.sv ***
// Serial receive path with two-entry buffer, error flags, APB registers and transmitter gating.
//
// Design decisions made here: the register offsets and register access over APB.
`include "uart_rx_consts.svh"

module uart_receiver_path (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RXD_PIN,
  input wire logic XCK_PIN,
  input wire logic TX_SHIFT_BUSY,
  input wire logic TX_BUFFER_FULL,
  output logic RX_PIN_OVERRIDE,
  output logic TX_PIN_OVERRIDE,
  output logic TX_ENABLE,
  output logic TX_NINTH_BIT,
  output logic IRQ_RXC
);

  // Control and format registers.
  logic rx_enable_ff;
  logic tx_enable_ff;
  logic rxc_irq_en_ff;
  logic tx_ninth_ff;
  logic sync_mode_ff;
  logic par_en_ff;
  logic par_type_ff;
  logic stop_sel_ff;
  logic [2:0] char_size_ff;
  logic [15:0] baud_ff;
  logic tx_override_ff;

  // Pin synchronisers.
  logic rxd_meta_ff;
  logic rxd_sync_ff;
  logic rxd_prev_ff;
  logic xck_meta_ff;
  logic xck_sync_ff;
  logic xck_prev_ff;

  // Receiver state.
  uart_rx_pkg::rx_state_e state_ff;
  logic [15:0] baud_cnt_ff;
  logic [3:0] bit_idx_ff;
  logic [8:0] shift_ff;
  logic par_bit_ff;
  logic par_chk_ff;

  // Completed frame waiting to enter the buffer.
  logic hold_valid_ff;
  uart_rx_pkg::rx_entry_s hold_ff;
  logic dor_pend_ff;

  // Two-entry receive buffer.
  uart_rx_pkg::rx_entry_s fifo_ff [0:1];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] count_ff;

  // APB response registers.
  logic [31:0] rdata_ff;
  logic slverr_ff;
  logic pop_ok_ff;

  logic apb_setup;
  logic apb_access;
  logic wr_access;
  logic data_read;
  logic pop;
  logic push;
  logic fifo_full;
  logic receive_complete_flag;
  uart_rx_pkg::rx_entry_s head;
  logic sample_tick;
  logic start_edge;
  logic start_valid;
  logic frame_done;
  logic [3:0] nbits;
  logic [8:0] data_mask;
  logic par_expect;
  logic [31:0] rd_mux;
  logic rd_hit;

  assign apb_setup = PSEL && !PENABLE;
  assign apb_access = PSEL && PENABLE;
  assign wr_access = apb_access && PWRITE;
  assign data_read = apb_access && !PWRITE && (PADDR == `OFS_DATA_IO);
  assign pop = data_read && pop_ok_ff && (count_ff != 2'h0); // RQ25
  assign push = hold_valid_ff && (count_ff != `RX_DEPTH) && rx_enable_ff;
  assign fifo_full = (count_ff == `RX_DEPTH);
  assign receive_complete_flag = (count_ff != 2'h0); // RQ10
  assign head = fifo_ff[rd_ptr_ff];

  // Control register writes.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rx_enable_ff <= 1'b0;
      tx_enable_ff <= 1'b0;
      rxc_irq_en_ff <= 1'b0;
      tx_ninth_ff <= 1'b0;
    end else if (wr_access && PADDR == `OFS_CONTROL_B) begin
      rx_enable_ff <= PWDATA[`BIT_RECEIVE_ENABLE_BIT];
      tx_enable_ff <= PWDATA[`BIT_TRANSMIT_ENABLE_BIT];
      rxc_irq_en_ff <= PWDATA[`BIT_RECEIVE_COMPLETE_IRQ_ENABLE];
      tx_ninth_ff <= PWDATA[`BIT_TRANSMIT_NINTH_BIT];
    end
  end

  // Frame format and baud divisor writes.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sync_mode_ff <= 1'((`RST_FRAME_FORMAT >> `BIT_SYNC_MODE) & 8'h01);
      par_en_ff <= 1'b0;
      par_type_ff <= 1'b0;
      stop_sel_ff <= 1'b0;
      char_size_ff <= 3'(`RST_FRAME_FORMAT & 8'h07);
      baud_ff <= `RST_BAUD_DIV;
    end else if (wr_access && PADDR == `OFS_FRAME_FORMAT) begin
      sync_mode_ff <= PWDATA[`BIT_SYNC_MODE];
      par_en_ff <= PWDATA[`BIT_PAR_EN];
      par_type_ff <= PWDATA[`BIT_PAR_TYPE];
      stop_sel_ff <= PWDATA[`BIT_STOP_SEL];
      char_size_ff <= PWDATA[`POS_CHAR_SIZE +: 3];
    end else if (wr_access && PADDR == `OFS_BAUD_DIV) begin
      baud_ff <= PWDATA[15:0];
    end
  end

  // The pin is taken as soon as the enable is set, but given back only once the
  // external transmitter reports both its shifter and its buffer empty.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      tx_override_ff <= 1'b0;
    end else if (tx_enable_ff) begin
      tx_override_ff <= 1'b1;
    end else if (!TX_SHIFT_BUSY && !TX_BUFFER_FULL) begin
      tx_override_ff <= 1'b0; // RQ1 RQ2
    end
  end

  assign TX_PIN_OVERRIDE = tx_override_ff; // RQ2
  assign TX_ENABLE = tx_override_ff; // RQ1
  assign TX_NINTH_BIT = tx_ninth_ff;
  assign RX_PIN_OVERRIDE = rx_enable_ff; // RQ3 RQ20

  // Two-stage synchronisers; only the second stage and its one-cycle delayed copy feed any logic.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rxd_meta_ff <= 1'b1;
      rxd_sync_ff <= 1'b1;
      rxd_prev_ff <= 1'b1;
      xck_meta_ff <= 1'b0;
      xck_sync_ff <= 1'b0;
      xck_prev_ff <= 1'b0;
    end else begin
      rxd_meta_ff <= RXD_PIN;
      rxd_sync_ff <= rxd_meta_ff;
      rxd_prev_ff <= rxd_sync_ff;
      xck_meta_ff <= XCK_PIN;
      xck_sync_ff <= xck_meta_ff;
      xck_prev_ff <= xck_sync_ff;
    end
  end

  // In synchronous mode each rising edge of the external clock is a bit slot.
  assign sample_tick = sync_mode_ff ? (xck_sync_ff && !xck_prev_ff) // RQ4
                                    : (baud_cnt_ff == 16'h0000);
  assign start_edge = !sync_mode_ff && rxd_prev_ff && !rxd_sync_ff;
  assign start_valid = rx_enable_ff && sample_tick && !rxd_sync_ff &&
                       ((state_ff == uart_rx_pkg::RX_START) ||
                        (state_ff == uart_rx_pkg::RX_IDLE && sync_mode_ff)); // RQ5
  assign frame_done = rx_enable_ff && sample_tick && (state_ff == uart_rx_pkg::RX_STOP);

  assign nbits = (char_size_ff == `CHAR_SIZE_9) ? 4'h9 : (4'h5 + {1'b0, char_size_ff[1:0]});
  assign data_mask = 9'h1ff >> (4'h9 - nbits);
  assign par_expect = (^(shift_ff & data_mask)) ^ par_type_ff; // RQ18 RQ24

  // Bit-period counter: half a period to the start-bit centre, then whole periods.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      baud_cnt_ff <= 16'h0000;
    end else if (!rx_enable_ff || state_ff == uart_rx_pkg::RX_IDLE) begin
      baud_cnt_ff <= baud_ff >> 1;
    end else if (baud_cnt_ff == 16'h0000) begin
      baud_cnt_ff <= baud_ff;
    end else begin
      baud_cnt_ff <= baud_cnt_ff - 16'h0001;
    end
  end

  // Frame sequencer. Returning to idle after the first stop bit means a second
  // stop bit is simply idle line and never looked at.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= uart_rx_pkg::RX_IDLE;
      bit_idx_ff <= 4'h0;
      shift_ff <= 9'h000;
      par_bit_ff <= 1'b0;
      par_chk_ff <= 1'b0;
    end else if (!rx_enable_ff) begin
      state_ff <= uart_rx_pkg::RX_IDLE; // RQ20
      bit_idx_ff <= 4'h0;
    end else begin
      unique case (state_ff)
        uart_rx_pkg::RX_IDLE: begin
          bit_idx_ff <= 4'h0;
          shift_ff <= 9'h000; // RQ8
          par_chk_ff <= par_en_ff; // RQ19
          if (start_valid) begin
            state_ff <= uart_rx_pkg::RX_DATA;
          end else if (start_edge) begin
            state_ff <= uart_rx_pkg::RX_START;
          end
        end
        uart_rx_pkg::RX_START: begin
          if (sample_tick) begin
            state_ff <= rxd_sync_ff ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_DATA; // RQ5
          end
        end
        uart_rx_pkg::RX_DATA: begin
          if (sample_tick) begin
            shift_ff[bit_idx_ff] <= rxd_sync_ff; // RQ5
            bit_idx_ff <= bit_idx_ff + 4'h1;
            if (bit_idx_ff == nbits - 4'h1) begin
              state_ff <= par_chk_ff ? uart_rx_pkg::RX_PARITY : uart_rx_pkg::RX_STOP;
            end
          end
        end
        uart_rx_pkg::RX_PARITY: begin
          if (sample_tick) begin
            par_bit_ff <= rxd_sync_ff;
            state_ff <= uart_rx_pkg::RX_STOP;
          end
        end
        uart_rx_pkg::RX_STOP: begin
          if (sample_tick) begin
            state_ff <= uart_rx_pkg::RX_IDLE; // RQ6
          end
        end
      endcase
    end
  end

  // Completed frame holding stage; it plays the role of the character still
  // waiting in the shift register once the buffer is full.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      hold_valid_ff <= 1'b0;
      hold_ff <= '0;
    end else if (!rx_enable_ff) begin
      hold_valid_ff <= 1'b0; // RQ11
    end else if (frame_done) begin
      hold_valid_ff <= 1'b1; // RQ7
      hold_ff.data <= shift_ff & data_mask; // RQ8
      hold_ff.fe <= !rxd_sync_ff; // RQ15
      hold_ff.pe <= par_chk_ff && (par_bit_ff != par_expect); // RQ19
      hold_ff.data_overrun_flag <= 1'b0;
    end else if (start_valid && fifo_full && hold_valid_ff) begin
      hold_valid_ff <= 1'b0; // RQ16
    end else if (push) begin
      hold_valid_ff <= 1'b0;
    end
  end

  // Overrun is remembered until the next frame reaches the buffer, and is then
  // stored with that frame. A fresh overrun in the same cycle as a push wins.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      dor_pend_ff <= 1'b0;
    end else if (!rx_enable_ff) begin
      dor_pend_ff <= 1'b0;
    end else if (start_valid && fifo_full && hold_valid_ff) begin
      dor_pend_ff <= 1'b1; // RQ16
    end else if (push) begin
      dor_pend_ff <= 1'b0; // RQ17
    end
  end

  // Buffer storage, one entry per generate slot.
  for (genvar i = 0; i < 2; i++) begin : g_entry
    always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
        fifo_ff[i] <= '0;
      end else if (push && wr_ptr_ff == 1'(i)) begin
        fifo_ff[i].data <= hold_ff.data; // RQ9
        fifo_ff[i].fe <= hold_ff.fe; // RQ9
        fifo_ff[i].pe <= hold_ff.pe; // RQ9
        fifo_ff[i].data_overrun_flag <= dor_pend_ff; // RQ9
      end
    end
  end

  // Buffer pointers; disabling the receiver empties the buffer at once.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
    end else if (!rx_enable_ff) begin
      wr_ptr_ff <= 1'b0; // RQ11
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_ff <= !wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= !rd_ptr_ff; // RQ9
      end
      if (push && !pop) begin
        count_ff <= count_ff + 2'h1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 2'h1;
      end
    end
  end

  // Level request, never fed by any error bit.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ_RXC <= 1'b0;
    end else begin
      IRQ_RXC <= rxc_irq_en_ff && receive_complete_flag && rx_enable_ff; // RQ12 RQ14
    end
  end

  // Read multiplexer; error bits are shown only while an entry is present.
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (PADDR)
      `OFS_STATUS_A: begin
        rd_mux[`BIT_RXC] = receive_complete_flag;
        rd_mux[`BIT_FE] = receive_complete_flag && head.fe; // RQ15
        rd_mux[`BIT_DOR] = receive_complete_flag && head.data_overrun_flag;
        rd_mux[`BIT_PE] = receive_complete_flag && head.pe;
      end
      `OFS_CONTROL_B: begin
        rd_mux[`BIT_RECEIVE_COMPLETE_IRQ_ENABLE] = rxc_irq_en_ff;
        rd_mux[`BIT_RECEIVE_ENABLE_BIT] = rx_enable_ff;
        rd_mux[`BIT_TRANSMIT_ENABLE_BIT] = tx_enable_ff;
        rd_mux[`BIT_RECEIVE_NINTH_BIT] = receive_complete_flag && head.data[8]; // RQ9
        rd_mux[`BIT_TRANSMIT_NINTH_BIT] = tx_ninth_ff;
      end
      `OFS_FRAME_FORMAT: begin
        rd_mux[`BIT_SYNC_MODE] = sync_mode_ff;
        rd_mux[`BIT_PAR_EN] = par_en_ff;
        rd_mux[`BIT_PAR_TYPE] = par_type_ff;
        rd_mux[`BIT_STOP_SEL] = stop_sel_ff;
        rd_mux[`POS_CHAR_SIZE +: 3] = char_size_ff;
      end
      `OFS_DATA_IO: begin
        rd_mux[8:0] = receive_complete_flag ? {1'b0, head.data[7:0]} : 9'h000; // RQ8
      end
      `OFS_BAUD_DIV: begin
        rd_mux[15:0] = baud_ff;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data is captured in the setup phase so the access phase can answer at
  // once from a flop. The pop only happens if the data shown was a real entry,
  // so a frame arriving between setup and access is never silently dropped.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_ff <= 32'h0000_0000;
      slverr_ff <= 1'b0;
      pop_ok_ff <= 1'b0;
    end else if (apb_setup) begin
      rdata_ff <= PWRITE ? 32'h0000_0000 : rd_mux;
      slverr_ff <= !rd_hit;
      pop_ok_ff <= receive_complete_flag; // RQ25
    end
  end

  // Writes to the status word change nothing, so the error bits stay put.
  assign PRDATA = rdata_ff; // RQ13
  assign PREADY = 1'b1;
  assign PSLVERR = apb_access && slverr_ff;

endmodule

// *** uart_rx_consts.svh ***
// Offsets, field positions, reset values and timing counts of the receive path.
// What this block does; RQ21 to RQ23 say what software must do
// RQ1 - Cleared transmit enable takes effect only once transmit shifter and buffer are empty.
// RQ2 - After the transmitter shuts down, the serial output pin returns to port use.
// RQ3 - Setting receive enable hands the serial input pin to the receiver.
// RQ4 - Synchronous mode samples bits on the external synchronous clock pin.
// RQ5 - Frames start on a valid start bit; bits shift in up to first stop.
// RQ6 - Only the first stop bit is checked; any second one is ignored.
// RQ7 - After the first stop bit the frame moves into the receive buffer.
// RQ8 - Data bits above the character size read as zero.
// RQ9 - Ninth bit and error bits live per buffer entry; a data read advances.
// RQ10 - Receive complete reads one while the buffer holds unread data.
// RQ11 - Clearing receive enable flushes the buffer and clears receive complete.
// RQ12 - Receive interrupt is a level held while enabled and receive complete is set.
// RQ13 - Frame, overrun and parity error bits ignore software writes.
// RQ14 - No error bit raises an interrupt.
// RQ15 - Frame error shows the first stop bit of the head entry sampled as zero.
// RQ16 - Overrun when a start bit comes with buffer full and a frame waiting.
// RQ17 - Pending overrun clears once a frame moves into the buffer.
// RQ18 - With parity enabled, compute odd or even parity and compare with received bit.
// RQ19 - Parity error stored per frame, only when checking was on; else zero.
// RQ20 - Clearing receive enable stops reception at once and frees the input pin.
// RQ21 - Software reads status and ninth bit before the data register.
// RQ22 - Software writes zero to error bit positions of the status register.
// RQ23 - Software empties the buffer by reading data until receive complete is zero.
// RQ24 - Parity type one selects odd parity, zero selects even parity.
// RQ25 - A data read on an empty buffer changes nothing.
`ifndef UART_RX_CONSTS_SVH
`define UART_RX_CONSTS_SVH

`define OFS_STATUS_A 12'h000
`define OFS_CONTROL_B 12'h004
`define OFS_FRAME_FORMAT 12'h008
`define OFS_DATA_IO 12'h00c
`define OFS_BAUD_DIV 12'h010

`define BIT_RXC 7
`define BIT_FE 4
`define BIT_DOR 3
`define BIT_PE 2

`define BIT_RECEIVE_COMPLETE_IRQ_ENABLE 7
`define BIT_RECEIVE_ENABLE_BIT 4
`define BIT_TRANSMIT_ENABLE_BIT 3
`define BIT_RECEIVE_NINTH_BIT 1
`define BIT_TRANSMIT_NINTH_BIT 0

`define BIT_SYNC_MODE 6
`define BIT_PAR_EN 5
`define BIT_PAR_TYPE 4
`define BIT_STOP_SEL 3
`define POS_CHAR_SIZE 0

`define RST_CONTROL_B 8'h00
`define RST_FRAME_FORMAT 8'h06
`define RST_BAUD_DIV 16'h0363
`define CHAR_SIZE_9 3'h7
`define RX_DEPTH 2'h2

`endif

// *** uart_rx_pkg.sv ***
// Types shared by the receive path.
package uart_rx_pkg;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP
  } rx_state_e;

  typedef struct packed {
    logic [8:0] data;
    logic fe;
    logic data_overrun_flag;
    logic pe;
  } rx_entry_s;

endpackage

// *** uart_receiver_path_chk.sv ***
// Port-level checker for the receive path, bound to its top module.
module uart_receiver_path_chk (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TX_SHIFT_BUSY,
  input wire logic TX_BUFFER_FULL,
  input wire logic RX_PIN_OVERRIDE,
  input wire logic TX_PIN_OVERRIDE,
  input wire logic TX_ENABLE,
  input wire logic IRQ_RXC
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  logic receive_complete_irq_enable_ff;
  logic receive_enable_bit_ff;
  logic transmit_enable_bit_ff;
  wire acc = PSEL && PENABLE;
  wire ctl_wr = acc && PWRITE && PADDR == 12'h004;
  wire data_rd = acc && !PWRITE && PADDR == 12'h00c;
  wire bad_adr = PADDR > 12'h010 || PADDR[1:0] != 2'h0;
  // Shadow of the control bits, so outputs can be tied to what software asked for.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      receive_complete_irq_enable_ff <= 1'b0;
      receive_enable_bit_ff <= 1'b0;
      transmit_enable_bit_ff <= 1'b0;
    end else if (ctl_wr) begin
      receive_complete_irq_enable_ff <= PWDATA[7];
      receive_enable_bit_ff <= PWDATA[4];
      transmit_enable_bit_ff <= PWDATA[3];
    end
  end
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_access;
    PSEL && PENABLE;
  endsequence
  chk_ready_always: assert property (PREADY) else $error("pready low");
  chk_err_in_access: assert property (PSLVERR |-> s_access) else $error("stray pslverr");
  chk_bad_addr_read: assert property (s_setup ##1 (acc && !PWRITE && bad_adr)
    |-> PRDATA == 32'h0 && PSLVERR) else $error("unmapped read not refused");
  chk_rx_pin_own: assert property (RX_PIN_OVERRIDE == receive_enable_bit_ff)
    else $error("input pin ownership wrong");
  chk_irq_gated: assert property (IRQ_RXC |-> receive_complete_irq_enable_ff || $past(receive_complete_irq_enable_ff))
    else $error("irq without enable");
  chk_irq_flushed: assert property (!receive_enable_bit_ff && !$past(receive_enable_bit_ff) |-> !IRQ_RXC)
    else $error("irq after flush");
  chk_irq_level: assert property (IRQ_RXC && receive_complete_irq_enable_ff && !data_rd && !$past(data_rd)
    && !ctl_wr && !$past(ctl_wr) |=> IRQ_RXC) else $error("irq dropped early");
  chk_tx_drain: assert property (TX_ENABLE && (TX_SHIFT_BUSY || TX_BUFFER_FULL)
    |=> TX_ENABLE) else $error("transmitter stopped while busy");
  chk_tx_stop: assert property (!transmit_enable_bit_ff && !TX_SHIFT_BUSY && !TX_BUFFER_FULL && !ctl_wr
    |-> ##[1:2] !TX_ENABLE) else $error("transmitter not stopped");
  chk_tx_pin_same: assert property (TX_PIN_OVERRIDE == TX_ENABLE)
    else $error("output pin ownership wrong");
endmodule

bind uart_receiver_path uart_receiver_path_chk chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TX_SHIFT_BUSY(TX_SHIFT_BUSY), .TX_BUFFER_FULL(TX_BUFFER_FULL),
  .RX_PIN_OVERRIDE(RX_PIN_OVERRIDE), .TX_PIN_OVERRIDE(TX_PIN_OVERRIDE),
  .TX_ENABLE(TX_ENABLE), .IRQ_RXC(IRQ_RXC)
);

// *** uart_line_model.sv ***
// Remote serial transmitter driving the receive line.
module uart_line_model #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic clk,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  task automatic put(input logic b);
    line <= b;
    repeat (BIT_CYCLES) @(posedge clk);
  endtask
  // Flip corrupts the parity bit; stop gives the first stop bit, the idle high follows.
  task automatic send(input logic [8:0] d, input int n, input logic pen, input logic odd,
                      input logic flip, input logic stop);
    logic p;
    p = odd ^ flip;
    put(1'b0);
    for (int i = 0; i < n; i++) begin
      put(d[i]);
      p = p ^ d[i];
    end
    if (pen) begin
      put(p);
    end
    put(stop);
    put(1'b1);
  endtask
endmodule

// *** uart_receiver_path_tb.sv ***
// Self-checking bench for the receive path.
module uart_receiver_path_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] csz;
    logic pen;
    logic odd;
    logic flip;
    logic stop;
    logic [8:0] d;
    logic [8:0] xd;
    logic fe;
    logic pe;
  } row_s;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic TX_SHIFT_BUSY = 1'b0;
  logic TX_BUFFER_FULL = 1'b0;
  logic RXD_PIN;
  logic XCK_PIN = 1'b0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic RX_PIN_OVERRIDE;
  logic TX_PIN_OVERRIDE;
  logic TX_ENABLE;
  logic TX_NINTH_BIT;
  logic IRQ_RXC;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int n_tests = 0;
  row_s rows [7] = '{
    '{3'h0, 1'b0, 1'b0, 1'b0, 1'b1, 9'h1ff, 9'h01f, 1'b0, 1'b0},
    '{3'h1, 1'b1, 1'b0, 1'b0, 1'b1, 9'h0a5, 9'h025, 1'b0, 1'b0},
    '{3'h2, 1'b1, 1'b1, 1'b1, 1'b1, 9'h155, 9'h055, 1'b0, 1'b1},
    '{3'h3, 1'b1, 1'b1, 1'b0, 1'b1, 9'h0c3, 9'h0c3, 1'b0, 1'b0},
    '{3'h3, 1'b0, 1'b0, 1'b1, 1'b0, 9'h03c, 9'h03c, 1'b1, 1'b0},
    '{3'h7, 1'b1, 1'b0, 1'b1, 1'b1, 9'h1a5, 9'h1a5, 1'b0, 1'b1},
    '{3'h7, 1'b0, 1'b0, 1'b0, 1'b1, 9'h0ff, 9'h0ff, 1'b0, 1'b0}};
  logic [7:0] ovr_st [3] = '{8'h80, 8'h80, 8'h88};
  logic [7:0] ovr_d [3] = '{8'h11, 8'h22, 8'h44};

  uart_receiver_path uut (
    .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RXD_PIN(RXD_PIN), .XCK_PIN(XCK_PIN), .TX_SHIFT_BUSY(TX_SHIFT_BUSY),
    .TX_BUFFER_FULL(TX_BUFFER_FULL), .RX_PIN_OVERRIDE(RX_PIN_OVERRIDE),
    .TX_PIN_OVERRIDE(TX_PIN_OVERRIDE), .TX_ENABLE(TX_ENABLE), .TX_NINTH_BIT(TX_NINTH_BIT),
    .IRQ_RXC(IRQ_RXC));
  uart_line_model #(.BIT_CYCLES(16)) far (.clk(CLOCK), .line(RXD_PIN));

  always #5 CLOCK = ~CLOCK;

  task automatic stop_test();
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Holds the request until pready is seen high, then takes the answer at that edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CLOCK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (k >= 50) begin
      check("pready wait", 32'h0, 32'h1);
      stop_test();
    end
    @(posedge CLOCK);
  endtask

  initial begin
    #500us;
    check("run time", 32'h0, 32'h1);
    stop_test();
  end

  initial begin
    repeat (10) @(posedge CLOCK);
    RST_N <= 1'b1;
    @(posedge CLOCK);
    apb(1'b0, 12'h004, 32'h0);
    check("control reset", rd, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    check("format reset", rd, 32'h6);
    apb(1'b0, 12'h010, 32'h0);
    check("baud reset", rd, 32'h363);
    apb(1'b0, 12'h014, 32'h0);
    check("unmapped error", 32'(err), 32'h1);
    apb(1'b1, 12'h010, 32'hf);
    apb(1'b1, 12'h004, 32'h10);
    check("rx pin", 32'(RX_PIN_OVERRIDE), 32'h1);
    foreach (rows[i]) begin
      apb(1'b1, 12'h008, {26'h0, rows[i].pen, rows[i].odd, 1'b1, rows[i].csz});
      far.send(rows[i].d, rows[i].csz == 3'h7 ? 9 : 5 + rows[i].csz, rows[i].pen,
               rows[i].odd, rows[i].flip, rows[i].stop);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      check("status", rd, {24'h0, 3'h4, rows[i].fe, 1'b0, rows[i].pe, 2'h0});
      check("irq off", 32'(IRQ_RXC), 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      check("ninth", rd, {24'h0, 6'h4, rows[i].xd[8], 1'b0});
      apb(1'b0, 12'h00c, 32'h0);
      check("data", rd, {24'h0, rows[i].xd[7:0]});
    end
    // Four frames with nothing read: two buffered, one waiting, one overrunning.
    apb(1'b1, 12'h008, 32'h3);
    apb(1'b1, 12'h004, 32'h90);
    for (int i = 1; i < 5; i++) begin
      far.send(9'(8'h11 * i), 8, 1'b0, 1'b0, 1'b0, 1'b1);
    end
    check("irq on", 32'(IRQ_RXC), 32'h1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 12'h000, 32'h0);
      check("overrun status", rd, {24'h0, ovr_st[i]});
      apb(1'b0, 12'h00c, 32'h0);
      check("overrun data", rd, {24'h0, ovr_d[i]});
    end
    repeat (2) @(posedge CLOCK);
    check("irq cleared", 32'(IRQ_RXC), 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    check("empty read", rd, 32'h0);
    far.send(9'h055, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    check("overrun cleared", rd, 32'h80);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    check("flushed", rd, 32'h0);
    check("rx pin freed", 32'(RX_PIN_OVERRIDE), 32'h0);
    far.send(9'h066, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    check("disabled rx", rd, 32'h0);
    TX_SHIFT_BUSY <= 1'b1;
    apb(1'b1, 12'h004, 32'h9);
    check("tx ninth", 32'(TX_NINTH_BIT), 32'h1);
    apb(1'b1, 12'h004, 32'h0);
    TX_SHIFT_BUSY <= 1'b0;
    TX_BUFFER_FULL <= 1'b1;
    repeat (4) @(posedge CLOCK);
    check("tx drains", 32'(TX_ENABLE), 32'h1);
    TX_BUFFER_FULL <= 1'b0;
    repeat (3) @(posedge CLOCK);
    check("tx off", 32'(TX_ENABLE), 32'h0);
    check("tx pin freed", 32'(TX_PIN_OVERRIDE), 32'h0);
    // Synchronous mode: one external clock rise in the middle of every bit slot.
    apb(1'b1, 12'h008, 32'h43);
    apb(1'b1, 12'h004, 32'h10);
    fork
      far.send(9'h0a7, 8, 1'b0, 1'b0, 1'b0, 1'b1);
      repeat (11) begin
        repeat (8) @(posedge CLOCK);
        XCK_PIN <= 1'b1;
        repeat (8) @(posedge CLOCK);
        XCK_PIN <= 1'b0;
      end
    join
    apb(1'b0, 12'h000, 32'h0);
    check("sync status", rd, 32'h80);
    apb(1'b0, 12'h00c, 32'h0);
    check("sync data", rd, 32'ha7);
    // Reset in mid-run must bring the control word and the pin ownership back.
    RST_N <= 1'b0;
    repeat (2) @(posedge CLOCK);
    RST_N <= 1'b1;
    @(posedge CLOCK);
    check("rx pin after reset", 32'(RX_PIN_OVERRIDE), 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    check("control after reset", rd, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    check("status after reset", rd, 32'h0);
    stop_test();
  end
endmodule
